// [rrs_core.sv]
// Datapath for the rotate right without carry and set all ones operations.
`timescale 1ns/100ps
module rrs_core
(
    input  wire logic        CLOCK,
    input  wire logic        RESETN,
    input  wire logic        CLK_EN,
    input  wire logic        INSTR_VALID,
    input  wire logic [15:0] INSTR_WORD,
    input  wire logic        EXT_ENABLE,
    input  wire logic [3:0]  BANK_SELECT_REGISTER,
    input  wire logic [11:0] INDEX_BASE,
    input  wire logic [7:0]  FILE_RDATA,
    output logic [11:0]      FILE_ADDR,
    output logic             FILE_RD,
    output logic             FILE_WR,
    output logic [7:0]       FILE_WDATA,
    output logic             WREG_WR,
    output logic [7:0]       WREG_WDATA,
    output logic             FLAG_WR,
    output logic             FLAG_N,
    output logic             FLAG_Z,
    output logic             DONE
);
    // Rotates a byte right by one without carry.
    function automatic logic [7:0] rot_right(input logic [7:0] v);
        rot_right = {v[0], v[rrs_pkg::MSB:1]};
    endfunction

    rrs_pkg::rrs_state_t state_r;
    logic [11:0]         gen_addr;
    logic                gen_indexed;
    logic                is_rot;
    logic                is_set;
    logic                rot_pend_r;
    logic                dest_r;
    logic [7:0]          result;

    // ------------------------------------------------------------------
    // Instruction decode.
    // ------------------------------------------------------------------
    assign is_rot = INSTR_WORD[rrs_pkg::OPC_HI:rrs_pkg::OPC6_LO]
                    == rrs_pkg::ROTATE_RIGHT_NO_CARRY_OP;
    assign is_set = INSTR_WORD[rrs_pkg::OPC_HI:rrs_pkg::OPC7_LO]
                    == rrs_pkg::SET_ALL_ONES_OP;
    assign result = rot_right(FILE_RDATA);

    // ------------------------------------------------------------------
    // Operand address from the banking mode of the instruction.
    // ------------------------------------------------------------------
    rrs_addr_gen u_addr
    (
        .f_operand            (INSTR_WORD[rrs_pkg::F_HI:0]),
        .access_sel           (INSTR_WORD[rrs_pkg::ACC_BIT]),
        .ext_enable           (EXT_ENABLE),
        .bank_select_register (BANK_SELECT_REGISTER),
        .index_base           (INDEX_BASE),
        .addr                 (gen_addr),
        .indexed              (gen_indexed)
    );

    // ------------------------------------------------------------------
    // Sequencing.
    // ------------------------------------------------------------------
    // Phase control: a rotate reads in the first cycle and writes in the
    // next; a set writes at once since no operand is needed.
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            state_r    <= rrs_pkg::RRS_IDLE;
            rot_pend_r <= 1'b0;
            dest_r     <= 1'b0;
        end
        else if (CLK_EN)
        begin
            unique case (state_r)
                rrs_pkg::RRS_IDLE:
                begin
                    if (INSTR_VALID && is_rot)
                    begin
                        state_r    <= rrs_pkg::RRS_EXEC;
                        rot_pend_r <= 1'b1;
                        dest_r     <= INSTR_WORD[rrs_pkg::DEST_BIT];
                    end
                end
                rrs_pkg::RRS_EXEC:
                begin
                    state_r    <= rrs_pkg::RRS_IDLE;
                    rot_pend_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs.
    // ------------------------------------------------------------------
    // Memory address and strobes.
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            FILE_ADDR  <= rrs_pkg::ZERO_ADDR;
            FILE_RD    <= 1'b0;
            FILE_WR    <= 1'b0;
            FILE_WDATA <= rrs_pkg::ZERO_BYTE;
        end
        else if (CLK_EN)
        begin
            FILE_RD <= 1'b0;
            FILE_WR <= 1'b0;
            if (state_r == rrs_pkg::RRS_IDLE && INSTR_VALID && is_rot)
            begin
                FILE_ADDR <= gen_addr;
                FILE_RD   <= 1'b1;
            end
            else if (state_r == rrs_pkg::RRS_IDLE && INSTR_VALID && is_set)
            begin
                FILE_ADDR  <= gen_addr;
                FILE_WR    <= 1'b1;
                FILE_WDATA <= rrs_pkg::ALL_ONES;
            end
            else if (rot_pend_r && dest_r)
            begin
                FILE_WR    <= 1'b1;
                FILE_WDATA <= result;
            end
        end
    end

    // Working register write and flag update for the rotate.
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            WREG_WR    <= 1'b0;
            WREG_WDATA <= rrs_pkg::ZERO_BYTE;
            FLAG_WR    <= 1'b0;
            FLAG_N     <= 1'b0;
            FLAG_Z     <= 1'b0;
            DONE       <= 1'b0;
        end
        else if (CLK_EN)
        begin
            WREG_WR <= rot_pend_r && !dest_r;
            FLAG_WR <= rot_pend_r;
            DONE    <= rot_pend_r || (state_r == rrs_pkg::RRS_IDLE
                       && INSTR_VALID && is_set);
            if (rot_pend_r)
            begin
                WREG_WDATA <= result;
                FLAG_N     <= result[rrs_pkg::MSB];
                FLAG_Z     <= result == rrs_pkg::ZERO_BYTE;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks on the outputs.
    // ------------------------------------------------------------------
    // A set writes all ones and leaves the flags alone.
    a_set_no_flags: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CLK_EN && state_r == rrs_pkg::RRS_IDLE && INSTR_VALID && is_set)
        |=> !FLAG_WR && FILE_WR && DONE
            && FILE_WDATA == rrs_pkg::ALL_ONES)
        else $error("Set all ones wrote flags or wrong data.");

    // A rotate writes exactly one destination, chosen by the d bit.
    a_rot_dest_sel: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CLK_EN && rot_pend_r)
        |=> (FILE_WR == dest_r) && (WREG_WR != dest_r) && DONE)
        else $error("Rotate result went to the wrong destination.");

    // The working register receives the operand rotated right by one.
    a_rot_value: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CLK_EN && rot_pend_r && !dest_r)
        |=> WREG_WDATA == {$past(FILE_RDATA[0]),
                           $past(FILE_RDATA[rrs_pkg::MSB:1])})
        else $error("Rotate value is wrong.");

    // A write-back carries the same rotated operand to the file.
    a_rot_file_val: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CLK_EN && rot_pend_r && dest_r)
        |=> FILE_WDATA == {$past(FILE_RDATA[0]),
                           $past(FILE_RDATA[rrs_pkg::MSB:1])})
        else $error("Rotate write-back value is wrong.");

    // With the access bit set, the bank select register names the bank.
    a_bank_sel: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CLK_EN && state_r == rrs_pkg::RRS_IDLE && INSTR_VALID
         && (is_rot || is_set) && INSTR_WORD[rrs_pkg::ACC_BIT])
        |=> FILE_ADDR == {$past(BANK_SELECT_REGISTER),
                          $past(INSTR_WORD[rrs_pkg::F_HI:0])})
        else $error("Bank select misrouted.");

    // With the access bit clear and no indexing, the access bank is used.
    a_access_bank: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CLK_EN && state_r == rrs_pkg::RRS_IDLE && INSTR_VALID
         && (is_rot || is_set) && !INSTR_WORD[rrs_pkg::ACC_BIT]
         && !(EXT_ENABLE
              && INSTR_WORD[rrs_pkg::F_HI:0] <= rrs_pkg::INDEXED_LIMIT))
        |=> FILE_ADDR[rrs_pkg::F_HI:0] == $past(INSTR_WORD[rrs_pkg::F_HI:0])
            && FILE_ADDR[rrs_pkg::ADDR_W-1:rrs_pkg::FADDR_W]
               == (FILE_ADDR[rrs_pkg::F_HI:0] < rrs_pkg::ACCESS_SPLIT
                   ? rrs_pkg::ACCESS_LO_BANK : rrs_pkg::ACCESS_HI_BANK))
        else $error("Access bank address is wrong.");

    // Indexed literal offset adds the operand to the index base.
    a_indexed_addr: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (CLK_EN && state_r == rrs_pkg::RRS_IDLE && INSTR_VALID
         && (is_rot || is_set) && !INSTR_WORD[rrs_pkg::ACC_BIT]
         && EXT_ENABLE
         && INSTR_WORD[rrs_pkg::F_HI:0] <= rrs_pkg::INDEXED_LIMIT)
        |=> (FILE_RD || FILE_WR) && FILE_ADDR == $past(INDEX_BASE)
            + {4'h0, $past(INSTR_WORD[rrs_pkg::F_HI:0])})
        else $error("Indexed address is wrong.");

    // A low clock enable freezes the sequencer and every output strobe.
    a_freeze_hold: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        !CLK_EN
        |=> $stable(state_r) && $stable(FILE_ADDR) && $stable(FILE_RD)
            && $stable(FILE_WR) && $stable(WREG_WR) && $stable(FLAG_WR)
            && $stable(DONE))
        else $error("State moved while the clock enable was low.");
endmodule

// [rrs_pkg.sv]
// Package with encodings, field positions and constants of the rotate unit.
package rrs_pkg;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned FADDR_W    = 8;
    localparam int unsigned BANK_W     = 4;
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned OPC_W      = 6;
    localparam int unsigned OPC7_W     = 7;
    // Six-bit opcode of the rotate right without carry operation.
    localparam logic [5:0]  ROTATE_RIGHT_NO_CARRY_OP = 6'h10;
    // Seven-bit opcode of the set all ones operation.
    localparam logic [6:0]  SET_ALL_ONES_OP          = 7'h34;
    // Instruction word fields.
    localparam int unsigned OPC_HI   = 15;
    localparam int unsigned OPC6_LO  = 10;
    localparam int unsigned OPC7_LO  = 9;
    localparam int unsigned DEST_BIT = 9;
    localparam int unsigned ACC_BIT  = 8;
    localparam int unsigned F_HI     = 7;
    // Highest file operand that uses indexed literal offset addressing.
    localparam logic [7:0]  INDEXED_LIMIT = 8'h5F;
    // Access bank split point: below it the low bank, at or above it bank F.
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
    localparam logic [7:0]  ALL_ONES      = 8'hFF;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    localparam logic [11:0] ZERO_ADDR     = 12'h000;
    localparam int unsigned MSB = 7;
    // Datapath phase of one instruction.
    typedef enum logic [1:0] {RRS_IDLE, RRS_EXEC} rrs_state_t;
endpackage

// [rrs_addr_gen.sv]
// Operand address generator for byte-oriented instructions.
`timescale 1ns/100ps
module rrs_addr_gen
(
    input  wire logic [7:0]  f_operand,
    input  wire logic        access_sel,
    input  wire logic        ext_enable,
    input  wire logic [3:0]  bank_select_register,
    input  wire logic [11:0] index_base,
    output logic [11:0]      addr,
    output logic             indexed
);
    // Forms the data-memory address from f, a, the bank register and
    // the index base when indexed literal offset addressing applies.
    always_comb
    begin
        indexed = !access_sel && ext_enable
                  && (f_operand <= rrs_pkg::INDEXED_LIMIT);
        if (indexed)
        begin
            addr = index_base + {4'h0, f_operand};
        end
        else if (access_sel)
        begin
            addr = {bank_select_register, f_operand};
        end
        else if (f_operand < rrs_pkg::ACCESS_SPLIT)
        begin
            addr = {rrs_pkg::ACCESS_LO_BANK, f_operand};
        end
        else
        begin
            addr = {rrs_pkg::ACCESS_HI_BANK, f_operand};
        end
    end
endmodule

// [tb_rrs_core.sv]
// Self-checking bench for the rotate/set datapath.
`timescale 1ns/100ps
`define CHK(n,e,g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_rrs_core;
    logic        clock, resetn, clk_en, instr_valid, ext_enable;
    logic        file_rd, file_wr, wreg_wr, flag_wr, flag_n, flag_z, done;
    logic [15:0] instr_word;
    logic [3:0]  bank;
    logic [11:0] index_base, file_addr;
    logic [7:0]  file_rdata, file_wdata, wreg_wdata, fv [4];
    int          err_total = 0, n_tests = 0, r, rx;
    integer      seed;

    rrs_core i_dut (.CLOCK(clock), .RESETN(resetn), .CLK_EN(clk_en),
        .INSTR_VALID(instr_valid), .INSTR_WORD(instr_word),
        .EXT_ENABLE(ext_enable), .BANK_SELECT_REGISTER(bank),
        .INDEX_BASE(index_base), .FILE_RDATA(file_rdata),
        .FILE_ADDR(file_addr), .FILE_RD(file_rd), .FILE_WR(file_wr),
        .FILE_WDATA(file_wdata), .WREG_WR(wreg_wr), .WREG_WDATA(wreg_wdata),
        .FLAG_WR(flag_wr), .FLAG_N(flag_n), .FLAG_Z(flag_z), .DONE(done));

    // Clock of 40 ns period.
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Expected operand address from the banking mode.
    function automatic logic [11:0] exp_addr(input logic [7:0] f,
                                             input logic a);
        if (!a && ext_enable && f <= rrs_pkg::INDEXED_LIMIT)
            return index_base + {4'h0, f};
        if (a)
            return {bank, f};
        return (f < rrs_pkg::ACCESS_SPLIT) ? {4'h0, f} : {4'hF, f};
    endfunction

    // Expected rotate right without carry: bit 0 wraps into bit 7.
    function automatic logic [7:0] exp_rot(input logic [7:0] x);
        return {x[0], x[7:1]};
    endfunction

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Issues one rotate and checks the read, the result and the flags;
    // with s set, the clock enable drops for two cycles after the read.
    task automatic rot(input logic [7:0] f, input logic d, input logic a,
                       input logic [7:0] x, input logic s);
        logic [7:0] e;
        e = exp_rot(x);
        instr_valid = 1'b1;
        instr_word = {rrs_pkg::ROTATE_RIGHT_NO_CARRY_OP, d, a, f};
        @(posedge clock);
        @(negedge clock);
        instr_valid = 1'b0;
        file_rdata = x;
        `CHK("rd", 1'b1, file_rd)
        `CHK("addr", exp_addr(f, a), file_addr)
        if (s)
        begin
            clk_en = 1'b0;
            repeat (2) @(negedge clock);
            `CHK("hold", 3'h4, {file_rd, file_wr, done})
            clk_en = 1'b1;
        end
        @(negedge clock);
        file_rdata = ~x;
        `CHK("wr", {d, ~d, 1'b1}, {file_wr, wreg_wr, done})
        `CHK("res", e, d ? file_wdata : wreg_wdata)
        `CHK("fwr", 1'b1, flag_wr)
        `CHK("nz", {e[7], e == 8'h00}, {flag_n, flag_z})
        `CHK("waddr", exp_addr(f, a), file_addr)
    endtask

    // Issues one set; the request stays up so sets may run back to back.
    task automatic setf1(input logic [7:0] f, input logic a);
        instr_valid = 1'b1;
        instr_word = {rrs_pkg::SET_ALL_ONES_OP, a, f};
        @(posedge clock);
        @(negedge clock);
        `CHK("set", 4'hA, {file_wr, wreg_wr, done, flag_wr})
        `CHK("sdat", rrs_pkg::ALL_ONES, file_wdata)
        `CHK("saddr", exp_addr(f, a), file_addr)
    endtask

    // Main sequence: corner cases, then random traffic, then a reset.
    initial
    begin
        seed = 32'h8965009C;
        fv = '{8'h00, 8'h5F, 8'h60, 8'hFF};
        resetn = 1'b0;
        clk_en = 1'b1;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        ext_enable = 1'b0;
        bank = 4'h5;
        index_base = 12'h3A0;
        file_rdata = 8'h00;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            ext_enable = i[0];
            rot(fv[i[3:2]], i[0] ^ i[1], i[1], i[0] ? 8'h01 : 8'h00,
                i[0] & i[1]);
            setf1(fv[i[3:2]], i[1]);
        end
        $display("corner test done");
        repeat (300)
        begin
            r = $random(seed);
            rx = $random(seed);
            ext_enable = r[0];
            bank = r[7:4];
            index_base = r[19:8];
            if (r[21:20] == 2'h0)
            begin
                instr_valid = 1'b1;
                instr_word = {6'h3F, r[31:22]};
                @(posedge clock);
                @(negedge clock);
                `CHK("ign", 2'h0, {file_rd, file_wr})
                `CHK("ign2", 2'h0, {wreg_wr, done})
            end
            else if (r[20])
                rot(r[31:24], r[22], r[23], rx[7:0], rx[8] & rx[9]);
            else
                setf1(r[31:24], r[23]);
        end
        $display("random test done");
        resetn = 1'b0;
        @(negedge clock);
        `CHK("rst", 3'h0, {file_rd, file_wr, wreg_wr})
        `CHK("rst2", 2'h0, {flag_wr, done})
        resetn = 1'b1;
        rot(8'h9C, 1'b1, 1'b1, 8'hA5, 1'b0);
        $display("reset test done");
        end_of_test;
    end

    // Cuts a hang short.
    initial
    begin
        repeat (100000) @(posedge clock);
        err_total++;
        end_of_test;
    end
endmodule
